// ---- rtl/drs_params.svh ----
`ifndef DRS_PARAMS_SVH
`define DRS_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define DRS_OFS_RAW_DONE 8'h00
`define DRS_OFS_RAW_ERR 8'h04
`define DRS_OFS_ACTIVE 8'h08
`define DRS_OFS_MASKED_DONE 8'h0c
`define DRS_OFS_DONE_CLR 8'h10
`define DRS_OFS_ERR_CLR 8'h14
`define DRS_OFS_DONE_EN 8'h18
`define DRS_OFS_IRQ_STS 8'h1c
`define DRS_OFS_IRQ_MASK 8'h20

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define DRS_NCH 2
`define DRS_EV_DONE_LSB 0
`define DRS_EV_ERR_LSB 2
`define DRS_RST_FLAGS 2'h0
`define DRS_RST_DONE_EN 2'h0
`define DRS_RST_IRQ 4'h0

`endif

// ---- rtl/drs_pkg.sv ----
package drs_pkg;

   // Per-channel flag state
   typedef struct packed {
      logic raw_done;
      logic raw_err;
      logic active;
   } drs_chan_st_t;

   // Register slice state
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq;
      logic [1:0] done_en;
      logic [3:0] irq_sts;
      logic [3:0] irq_mask;
   } drs_core_st_t;

endpackage

// ---- rtl/drs_flag_if.sv ----
interface drs_flag_if;
   logic done_set;
   logic err_set;
   logic start;
   logic cnt_zero;
   logic done_clr;
   logic err_clr;
   logic raw_done;
   logic raw_err;
   logic active;

   modport core
   (
      output done_set, err_set, start, cnt_zero, done_clr, err_clr,
      input raw_done, raw_err, active
   );
   modport chan
   (
      input done_set, err_set, start, cnt_zero, done_clr, err_clr,
      output raw_done, raw_err, active
   );
endinterface

// ---- rtl/drs_chan.sv ----
`include "drs_params.svh"

module drs_chan
(
   drs_flag_if.chan fl,
   input wire logic pclk,
   input wire logic presetn
);

   drs_pkg::drs_chan_st_t s_r;
   drs_pkg::drs_chan_st_t s_nxt;

   // ----------------------------------------
   // Flag update
   // ----------------------------------------
   // Sticky flags, set beats clear in the same cycle
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.raw_done = (s_r.raw_done & ~fl.done_clr) | fl.done_set;
      s_nxt.raw_err = (s_r.raw_err & ~fl.err_clr) | fl.err_set;
      if (fl.cnt_zero)
      begin
         s_nxt.active = 1'b0;
      end
      if (fl.start)
      begin
         s_nxt.active = 1'b1;
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // Flags back to the register slice
   assign fl.raw_done = s_r.raw_done;
   assign fl.raw_err = s_r.raw_err;
   assign fl.active = s_r.active;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   AST_CH_ERR_HOLD: assert property (
      @(posedge pclk) disable iff (!presetn)
      (s_r.raw_err && !fl.err_clr) |=> s_r.raw_err)
      else $error("raw fault flag dropped without clear");

endmodule

// ---- rtl/drs_top.sv ----
// Decided for this implementation: the register offsets and the APB interface to the registers.
`include "drs_params.svh"

// Contract
// - Each channel has a read-only raw done flag, set on transfer end.
// - Each channel has a read-only raw fault flag, set on error.
// - Active flags sit in bits 0 and 1, one while channel enabled.
// - Active flag clears itself when the remaining count reaches zero.
// - Masked done status shows raw done only where done interrupt enabled.
// - Writing one to a clear bit clears that done flag; zero does nothing.
module drs_top
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire logic [1:0] ch_done,
   input wire logic [1:0] ch_err,
   input wire logic [1:0] ch_start,
   input wire logic [1:0] ch_cnt_zero,
   output logic [1:0] ch_active
);

   drs_pkg::drs_core_st_t s_r;
   drs_pkg::drs_core_st_t s_nxt;
   logic [1:0] raw_done;
   logic [1:0] raw_err;
   logic [1:0] done_clr_v;
   logic [1:0] err_clr_v;
   logic setup;
   logic acc;
   logic wr;
   logic rd;
   logic [3:0] sts_clr;

   // Address match, used for every register
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // ----------------------------------------
   // Channel flag slices
   // ----------------------------------------
   drs_flag_if fl[`DRS_NCH] ();

   genvar gi;
   generate
      for (gi = 0; gi < `DRS_NCH; gi++)
      begin : g_ch
         // Hook one channel to its events and clears
         assign fl[gi].done_set = ch_done[gi];
         assign fl[gi].err_set = ch_err[gi];
         assign fl[gi].start = ch_start[gi];
         assign fl[gi].cnt_zero = ch_cnt_zero[gi];
         assign fl[gi].done_clr = done_clr_v[gi];
         assign fl[gi].err_clr = err_clr_v[gi];
         assign raw_done[gi] = fl[gi].raw_done;
         assign raw_err[gi] = fl[gi].raw_err;
         assign ch_active[gi] = fl[gi].active;

         drs_chan u_chan
         (
            .fl(fl[gi]),
            .pclk(pclk),
            .presetn(presetn)
         );
      end
   endgenerate

   // ----------------------------------------
   // APB slave and interrupt logic
   // ----------------------------------------
   // Bus phases and write strobes
   always_comb
   begin
      setup = psel & ~penable;
      acc = psel & penable & s_r.pready;
      wr = acc & pwrite;
      rd = acc & ~pwrite;
      done_clr_v = (wr && hit(paddr, `DRS_OFS_DONE_CLR)) ? pwdata[1:0]
                   : 2'h0;
      err_clr_v = (wr && hit(paddr, `DRS_OFS_ERR_CLR)) ? pwdata[1:0]
                  : 2'h0;
      // Only bits shown to software are cleared by the read
      sts_clr = (rd && hit(paddr, `DRS_OFS_IRQ_STS)) ? s_r.prdata[3:0]
                : 4'h0;
   end

   // Next state of the register slice
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.pready = setup;
      s_nxt.pslverr = 1'b0;
      if (wr && hit(paddr, `DRS_OFS_DONE_EN))
      begin
         s_nxt.done_en = pwdata[1:0];
      end
      if (wr && hit(paddr, `DRS_OFS_IRQ_MASK))
      begin
         s_nxt.irq_mask = pwdata[3:0];
      end
      s_nxt.irq_sts = (s_r.irq_sts & ~sts_clr) | {ch_err, ch_done};
      s_nxt.irq = |(s_nxt.irq_sts & s_nxt.irq_mask);
      if (setup)
      begin
         s_nxt.prdata = 32'h0;
         if (hit(paddr, `DRS_OFS_RAW_DONE))
         begin
            s_nxt.prdata[1:0] = raw_done;
         end
         else if (hit(paddr, `DRS_OFS_RAW_ERR))
         begin
            s_nxt.prdata[1:0] = raw_err;
         end
         else if (hit(paddr, `DRS_OFS_ACTIVE))
         begin
            s_nxt.prdata[1:0] = ch_active;
         end
         else if (hit(paddr, `DRS_OFS_MASKED_DONE))
         begin
            s_nxt.prdata[1:0] = raw_done & s_r.done_en;
         end
         else if (hit(paddr, `DRS_OFS_DONE_EN))
         begin
            s_nxt.prdata[1:0] = s_r.done_en;
         end
         else if (hit(paddr, `DRS_OFS_IRQ_STS))
         begin
            s_nxt.prdata[3:0] = s_r.irq_sts;
         end
         else if (hit(paddr, `DRS_OFS_IRQ_MASK))
         begin
            s_nxt.prdata[3:0] = s_r.irq_mask;
         end
         else if (!hit(paddr, `DRS_OFS_DONE_CLR) &&
                  !hit(paddr, `DRS_OFS_ERR_CLR))
         begin
            s_nxt.pslverr = 1'b1; // Unmapped address
         end
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from flops
   assign prdata = s_r.prdata;
   assign pready = s_r.pready;
   assign pslverr = s_r.pslverr;
   assign irq = s_r.irq;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   AST_RAW_DONE_SET: assert property ((ch_done != 2'h0) |=>
      ((raw_done & $past(ch_done)) == $past(ch_done)))
      else $error("raw done flag not set by transfer end");

   AST_RAW_ERR_SET: assert property ((ch_err != 2'h0) |=>
      ((raw_err & $past(ch_err)) == $past(ch_err)))
      else $error("raw fault flag not set by error");

   AST_ACTIVE_READ: assert property (
      (setup && hit(paddr, `DRS_OFS_ACTIVE)) |=>
      (pready && prdata == {30'h0, $past(ch_active)}))
      else $error("active read data wrong");

   AST_ACTIVE_CLEAR: assert property (
      ((ch_cnt_zero & ~ch_start) != 2'h0) |=>
      ((ch_active & $past(ch_cnt_zero & ~ch_start)) == 2'h0))
      else $error("active flag kept after count zero");

   AST_MASKED_READ: assert property (
      (setup && hit(paddr, `DRS_OFS_MASKED_DONE)) |=>
      (prdata == {30'h0, $past(raw_done & s_r.done_en)}))
      else $error("masked done read data wrong");

   AST_DONE_CLEAR: assert property (
      (wr && hit(paddr, `DRS_OFS_DONE_CLR)) |=>
      ((raw_done & $past(pwdata[1:0] & ~ch_done)) == 2'h0))
      else $error("done flag not cleared by write");

   AST_DONE_HOLD: assert property (
      ((raw_done & ~done_clr_v) != 2'h0) |=>
      ((raw_done & $past(raw_done & ~done_clr_v)) ==
       $past(raw_done & ~done_clr_v)))
      else $error("done flag dropped without clear");

   AST_IRQ_LEVEL: assert property ((ch_done[0] && s_r.irq_mask[0]) |=>
      irq)
      else $error("interrupt not raised for unmasked event");

   AST_ONE_WAIT: assert property (setup |=> pready ##1 !pready)
      else $error("pready not a single access cycle");

endmodule

// ---- bench/drs_tb_top.sv ----
`include "drs_params.svh"

module drs_tb_top;
   timeunit 1ns;
   timeprecision 1ns;

   // ----------------------------------------
   // Signals and model state
   // ----------------------------------------
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, seed;
   logic [1:0] ch_done, ch_err, ch_start, ch_cnt_zero, ch_active;
   int bad_count, tests_run, cycles;
   int m_done, m_err, m_act, m_en, m_sts, m_mask;

   drs_top dut
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .ch_done(ch_done),
      .ch_err(ch_err), .ch_start(ch_start), .ch_cnt_zero(ch_cnt_zero),
      .ch_active(ch_active)
   );

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // Compares one result against the model
   task automatic chk(input logic [31:0] got, input int exp, input string s);
      tests_run++;
      if (got !== exp[31:0])
      begin
         bad_count++;
         $display("wrong value at %0t: %s got %h exp %h", $time, s, got, exp);
      end
   endtask

   // One APB transfer, entered just after a rising edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Look at pready mid-cycle, where it has settled
      do
      begin
         @(negedge pclk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      // Release only after the edge that samples pready high
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Read and compare data and error flag
   task automatic rd_chk(input logic [7:0] a, input int exp, input string s);
      apb(1'b0, a, 32'h0);
      chk(rd, exp, s);
      chk({31'h0, err}, 0, "error flag");
   endtask

   // One cycle of channel events, then pin checks
   task automatic ev(input logic [1:0] d, e, s, z);
      ch_done <= d;
      ch_err <= e;
      ch_start <= s;
      ch_cnt_zero <= z;
      @(posedge pclk);
      ch_done <= 2'h0;
      ch_err <= 2'h0;
      ch_start <= 2'h0;
      ch_cnt_zero <= 2'h0;
      m_done |= d;
      m_err |= e;
      m_sts |= {e, d};
      m_act = s | (m_act & ~z);
      @(posedge pclk);
      chk({30'h0, ch_active}, m_act, "active pin");
      chk({31'h0, irq}, (m_sts & m_mask) != 0, "irq pin");
   endtask

   task report_and_stop;
      $display("compares %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ----------------------------------------
   // Clock and timeout
   // ----------------------------------------
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         bad_count++;
         report_and_stop();
      end
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {ch_done, ch_err, ch_start, ch_cnt_zero} = '0;
      seed = 32'h7a27;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int a = 0; a <= 32; a += 4)
         rd_chk(8'(a), 0, "reset value");
      apb(1'b0, 8'h24, 32'h0);
      chk({31'h0, err}, 1, "unmapped error");
      chk(rd, 0, "unmapped data");
      apb(1'b1, `DRS_OFS_RAW_DONE, 32'h3);
      $display("test reset and map done");
      for (int i = 0; i < 40; i++)
      begin
         repeat (8) seed = lfsr(seed);
         ev(seed[1:0], seed[3:2], seed[5:4], seed[7:6]);
         rd_chk(`DRS_OFS_RAW_DONE, m_done, "raw done");
         rd_chk(`DRS_OFS_RAW_ERR, m_err, "raw fault");
         rd_chk(`DRS_OFS_ACTIVE, m_act, "active reg");
         rd_chk(`DRS_OFS_MASKED_DONE, m_done & m_en, "masked");
         if (seed[8])
         begin
            apb(1'b1, `DRS_OFS_DONE_CLR, {30'h0, seed[10:9]});
            m_done &= ~seed[10:9];
         end
         if (seed[11])
         begin
            apb(1'b1, `DRS_OFS_ERR_CLR, {30'h0, seed[13:12]});
            m_err &= ~seed[13:12];
         end
         if (seed[14])
         begin
            apb(1'b1, `DRS_OFS_DONE_EN, {30'h0, seed[16:15]});
            m_en = seed[16:15];
         end
         if (seed[17])
         begin
            apb(1'b1, `DRS_OFS_IRQ_MASK, {28'h0, seed[21:18]});
            m_mask = seed[21:18];
         end
         if (seed[22])
         begin
            rd_chk(`DRS_OFS_IRQ_STS, m_sts, "irq status");
            m_sts = 0;
         end
         chk({31'h0, irq}, (m_sts & m_mask) != 0, "irq after access");
      end
      $display("test random events done");
      report_and_stop();
   end
endmodule
